// >>> dcca_core.sv
`timescale 1ns/1ps
module dcca_core
    import dcca_pkg::*;
#(
    parameter int N_CH = NUM_CH,
    parameter int N_TMR = NUM_TMR
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // channel pins
    input wire logic [N_CH-1:0] cc_pin_in,
    output logic [N_CH-1:0] cc_pin_out,
    output logic [N_CH-1:0] cc_pin_oe,
    // count sources
    input wire logic [NUM_UNITS-1:0] ext_count_in,
    input wire logic gp_timer_ovf,
    // interrupt requests
    output logic [N_CH-1:0] chan_irq,
    output logic [N_TMR-1:0] timer_irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [N_CH-1:0][TMR_W-1:0] ch_val;
        logic [N_CH-1:0][MODE_W-1:0] ch_mode;
        logic [N_CH-1:0] ch_tsel;
        logic [N_CH-1:0][EDGE_W-1:0] ch_edge;
        logic [N_CH-1:0] ch_flag;
        logic [N_CH-1:0] ch_done;
        logic [N_CH-1:0] pin_lvl;
        logic [N_CH-1:0] pin_s1;
        logic [N_CH-1:0] pin_s2;
        logic [N_CH-1:0] pin_prev;
        logic [N_TMR-1:0][TMR_W-1:0] t_cnt;
        logic [N_TMR-1:0][TMR_W-1:0] t_rld;
        logic [N_TMR-1:0][SEL_W-1:0] t_sel;
        logic [N_TMR-1:0][SRC_W-1:0] t_src;
        logic [N_TMR-1:0] t_run;
        logic [N_TMR-1:0] t_step;
        logic [N_TMR-1:0] t_ovf;
        logic [N_TMR-1:0] t_flag;
        logic [NUM_UNITS-1:0] ext_s1;
        logic [NUM_UNITS-1:0] ext_s2;
        logic [NUM_UNITS-1:0] ext_prev;
        logic [PRESC_W-1:0] presc;
        logic ack;
        logic [31:0] dat;
    } dcca_state_s;

    dcca_state_s q;
    dcca_state_s d;

    // ----------------------------------------------------------------
    // byte-lane merge
    // ----------------------------------------------------------------
    function automatic logic [31:0] dcca_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // per-channel event decode
    // ----------------------------------------------------------------
    logic [N_CH-1:0][1:0] tix_w;
    logic [N_CH-1:0][TMR_W-1:0] tval_w;
    logic [N_CH-1:0] match_w;
    logic [N_CH-1:0] cap_w;
    logic [N_CH-1:0] ovf_w;
    logic [N_CH-1:0] dbl_tog_w;
    logic [N_CH-1:0] drive_w;

    generate
        for (genvar c = 0; c < N_CH; c++) begin : g_ch
            localparam logic UNIT_BIT = 1'(c / CH_PER_UNIT);
            localparam int LOCAL = c % CH_PER_UNIT;
            localparam bit IN_ONLY = (c >= INPUT_ONLY_CHANNEL_FIRST) &&
                                     (c <= INPUT_ONLY_CHANNEL_LAST);
            logic rise;
            logic fall;
            logic pair_dbl;
            // unit bit is fixed per channel, so unit two never sees unit one timers
            assign tix_w[c] = {UNIT_BIT, q.ch_tsel[c]};
            assign tval_w[c] = q.t_cnt[tix_w[c]];
            assign ovf_w[c] = q.t_ovf[tix_w[c]];
            // only a fresh timer step can match, a parked timer stays quiet
            assign match_w[c] = q.t_step[tix_w[c]] && (q.ch_val[c] == tval_w[c]);
            assign rise = q.pin_s2[c] & ~q.pin_prev[c];
            assign fall = ~q.pin_s2[c] & q.pin_prev[c];
            assign cap_w[c] = (q.ch_mode[c] == MODE_CAPTURE) &&
                              ((q.ch_edge[c][EDGE_RISE_BIT] && rise) ||
                               (q.ch_edge[c][EDGE_FALL_BIT] && fall));
            // upper half of a unit never indexes past its partner
            if (LOCAL < DOUBLE_PAIR_OFFSET) begin : g_lo
                assign pair_dbl = (q.ch_mode[c] == MODE_DOUBLE) ||
                                  (q.ch_mode[c+DOUBLE_PAIR_OFFSET] == MODE_DOUBLE);
                assign dbl_tog_w[c] =
                    ((q.ch_mode[c] == MODE_DOUBLE) && match_w[c]) ||
                    ((q.ch_mode[c+DOUBLE_PAIR_OFFSET] == MODE_DOUBLE) &&
                     match_w[c+DOUBLE_PAIR_OFFSET]);
            end else begin : g_hi
                assign pair_dbl = 1'b0;
                assign dbl_tog_w[c] = 1'b0;
            end
            if (IN_ONLY) begin : g_in
                assign drive_w[c] = 1'b0;
            end else begin : g_out
                assign drive_w[c] = (q.ch_mode[c] == MODE_CMP1) ||
                                    (q.ch_mode[c] == MODE_CMP3) ||
                                    pair_dbl;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [ADDR_W-1:0] word;
        logic [4:0] cidx;
        logic [1:0] tidx;
        logic req;
        logic wr;
        logic [31:0] rdata;
        logic [31:0] m;
        logic [PRESC_W-1:0] pmask;
        logic tick;
        logic ext_rise;
        logic [N_CH-1:0] ch_set;
        logic [N_CH-1:0] ch_clr;
        logic [N_TMR-1:0] t_set;
        logic [N_TMR-1:0] t_clr;
        word = {wb_adr_i[ADDR_W-1:2], 2'b00};
        cidx = word[6:2];
        tidx = word[3:2];
        req = wb_cyc_i && wb_stb_i;
        wr = req && wb_we_i && q.ack;
        rdata = 32'h0000_0000;
        m = 32'h0000_0000;
        pmask = '0;
        tick = 1'b0;
        ext_rise = 1'b0;
        ch_set = '0;
        ch_clr = '0;
        t_set = '0;
        t_clr = '0;
        d = q;

        // --------------------------------------------------------
        // synchronisers
        // --------------------------------------------------------
        d.pin_s1 = cc_pin_in;
        d.pin_s2 = q.pin_s1;
        d.pin_prev = q.pin_s2;
        d.ext_s1 = ext_count_in;
        d.ext_s2 = q.ext_s1;
        d.ext_prev = q.ext_s2;

        // --------------------------------------------------------
        // prescaler and base timers
        // --------------------------------------------------------
        d.presc = q.presc + 1'b1;
        for (int t = 0; t < N_TMR; t++) begin
            // power-of-two factors all share one free running divider
            pmask = PRESC_W'((1 << (int'(q.t_sel[t]) + PRESC_BASE_LOG2)) - 1);
            ext_rise = q.ext_s2[t/2] && !q.ext_prev[t/2];
            case (q.t_src[t])
                SRC_PRESCALE: tick = ((q.presc & pmask) == pmask);
                SRC_GP_OVF: tick = gp_timer_ovf;
                SRC_EXT: tick = ((t % 2) == 0) && ext_rise;
                default: tick = 1'b0;
            endcase
            tick = tick && q.t_run[t];
            d.t_step[t] = tick;
            d.t_ovf[t] = tick && (q.t_cnt[t] == TMR_MAX);
            if (tick) begin
                if (q.t_cnt[t] == TMR_MAX) begin
                    d.t_cnt[t] = q.t_rld[t];
                end else begin
                    d.t_cnt[t] = q.t_cnt[t] + 1'b1;
                end
            end
            t_set[t] = d.t_ovf[t];
        end

        // --------------------------------------------------------
        // channels
        // --------------------------------------------------------
        for (int c = 0; c < N_CH; c++) begin
            if (cap_w[c]) begin
                d.ch_val[c] = tval_w[c];
                ch_set[c] = 1'b1;
            end
            if (ovf_w[c]) begin
                d.ch_done[c] = 1'b0;
                if (q.ch_mode[c] == MODE_CMP3) begin
                    d.pin_lvl[c] = 1'b0;
                end
            end
            if (match_w[c]) begin
                case (q.ch_mode[c])
                    MODE_CMP0: ch_set[c] = 1'b1;
                    MODE_CMP1: begin
                        d.pin_lvl[c] = ~q.pin_lvl[c];
                        ch_set[c] = 1'b1;
                    end
                    MODE_CMP2: begin
                        if (!q.ch_done[c]) begin
                            ch_set[c] = 1'b1;
                            d.ch_done[c] = 1'b1;
                        end
                    end
                    MODE_CMP3: begin
                        if (!q.ch_done[c]) begin
                            d.pin_lvl[c] = 1'b1;
                            ch_set[c] = 1'b1;
                            d.ch_done[c] = 1'b1;
                        end
                    end
                    MODE_DOUBLE: ch_set[c] = 1'b1;
                    default: ;
                endcase
            end
            if (dbl_tog_w[c]) begin
                d.pin_lvl[c] = ~q.pin_lvl[c];
            end
        end

        // --------------------------------------------------------
        // bus read
        // --------------------------------------------------------
        if ((word & ~CH_IDX_MASK) == ADDR_CH_VAL) begin
            rdata[TMR_W-1:0] = q.ch_val[cidx];
        end else if ((word & ~CH_IDX_MASK) == ADDR_CH_CTL) begin
            rdata[CTL_MODE_LSB +: MODE_W] = q.ch_mode[cidx];
            rdata[CTL_TSEL_BIT] = q.ch_tsel[cidx];
            rdata[CTL_EDGE_LSB +: EDGE_W] = q.ch_edge[cidx];
        end else if ((word & ~TMR_IDX_MASK) == ADDR_TMR_CNT) begin
            rdata[TMR_W-1:0] = q.t_cnt[tidx];
        end else if ((word & ~TMR_IDX_MASK) == ADDR_TMR_RLD) begin
            rdata[TMR_W-1:0] = q.t_rld[tidx];
        end else if ((word & ~TMR_IDX_MASK) == ADDR_TMR_CTL) begin
            rdata[TC_SEL_LSB +: SEL_W] = q.t_sel[tidx];
            rdata[TC_SRC_LSB +: SRC_W] = q.t_src[tidx];
            rdata[TC_RUN_BIT] = q.t_run[tidx];
        end else if (word == ADDR_CH_FLAG) begin
            rdata[N_CH-1:0] = q.ch_flag;
        end else if (word == ADDR_TMR_FLAG) begin
            rdata[N_TMR-1:0] = q.t_flag;
        end else if (word == ADDR_PIN_LVL) begin
            rdata[N_CH-1:0] = q.pin_lvl;
        end else if (word == ADDR_PIN_IN) begin
            rdata[N_CH-1:0] = q.pin_s2;
        end

        // ack one cycle after the request, data captured alongside it
        d.ack = req && !q.ack;
        if (req && !q.ack) begin
            d.dat = rdata;
        end

        // --------------------------------------------------------
        // bus write: software wins over hardware on data fields
        // --------------------------------------------------------
        m = dcca_merge(rdata, wb_dat_i, wb_sel_i);
        if (wr) begin
            if ((word & ~CH_IDX_MASK) == ADDR_CH_VAL) begin
                d.ch_val[cidx] = m[TMR_W-1:0];
            end else if ((word & ~CH_IDX_MASK) == ADDR_CH_CTL) begin
                d.ch_mode[cidx] = m[CTL_MODE_LSB +: MODE_W];
                d.ch_tsel[cidx] = m[CTL_TSEL_BIT];
                d.ch_edge[cidx] = m[CTL_EDGE_LSB +: EDGE_W];
                d.ch_done[cidx] = 1'b0;
            end else if ((word & ~TMR_IDX_MASK) == ADDR_TMR_CNT) begin
                d.t_cnt[tidx] = m[TMR_W-1:0];
            end else if ((word & ~TMR_IDX_MASK) == ADDR_TMR_RLD) begin
                d.t_rld[tidx] = m[TMR_W-1:0];
            end else if ((word & ~TMR_IDX_MASK) == ADDR_TMR_CTL) begin
                d.t_sel[tidx] = m[TC_SEL_LSB +: SEL_W];
                d.t_src[tidx] = m[TC_SRC_LSB +: SRC_W];
                d.t_run[tidx] = m[TC_RUN_BIT];
            end else if (word == ADDR_CH_FLAG) begin
                ch_clr = dcca_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
            end else if (word == ADDR_TMR_FLAG) begin
                t_clr = wb_dat_i[N_TMR-1:0] & {N_TMR{wb_sel_i[0]}};
            end
        end

        // --------------------------------------------------------
        // sticky flags: a set in the clearing cycle survives
        // --------------------------------------------------------
        d.ch_flag = (q.ch_flag & ~ch_clr) | ch_set;
        d.t_flag = (q.t_flag & ~t_clr) | t_set;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.dat;
    assign cc_pin_out = q.pin_lvl;
    assign cc_pin_oe = drive_w;
    assign chan_irq = q.ch_flag;
    assign timer_irq = q.t_flag;

endmodule

// >>> dcca_pkg.sv
// What this block does
// - two units, sixteen channels each, 32 total
// - four 16-bit base timers with reload, paired
// - timer clock: prescaled clock or gp overflow
// - first timer of unit counts external pin
// - channel picks timer, capture or compare
// - unit two channels use unit two timers
// - one pin per channel; 24..27 input only
// - capture copies allocated timer on pin event
// - every capture raises its channel request
// - capture edge: rising, falling or both
// - compare channels match timer, then act
// - mode 0: request only, many per period
// - mode 1: pin toggles on every match
// - mode 2: request only, once per period
// - mode 3: pin high on match, low overflow
// - double mode: pair shares pin, toggles
// - select codes give prescale 8 to 1024
// - overflow restarts timer from reload value
package dcca_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_UNITS = 2;
    localparam int CH_PER_UNIT = 16;
    localparam int NUM_CH = 32;
    localparam int NUM_TMR = 4;
    localparam int TMR_W = 16;
    localparam int ADDR_W = 9;
    localparam int PRESC_W = 10;
    localparam int PRESC_BASE_LOG2 = 3;
    localparam int DOUBLE_PAIR_OFFSET = 8;
    localparam int INPUT_ONLY_CHANNEL_FIRST = 24;
    localparam int INPUT_ONLY_CHANNEL_LAST = 27;
    localparam logic [TMR_W-1:0] TMR_MAX = 16'hFFFF;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CH_VAL = 9'h000;
    localparam logic [ADDR_W-1:0] ADDR_CH_CTL = 9'h080;
    localparam logic [ADDR_W-1:0] ADDR_TMR_CNT = 9'h100;
    localparam logic [ADDR_W-1:0] ADDR_TMR_RLD = 9'h110;
    localparam logic [ADDR_W-1:0] ADDR_TMR_CTL = 9'h120;
    localparam logic [ADDR_W-1:0] ADDR_CH_FLAG = 9'h130;
    localparam logic [ADDR_W-1:0] ADDR_TMR_FLAG = 9'h134;
    localparam logic [ADDR_W-1:0] ADDR_PIN_LVL = 9'h138;
    localparam logic [ADDR_W-1:0] ADDR_PIN_IN = 9'h13C;
    localparam logic [ADDR_W-1:0] CH_IDX_MASK = 9'h07C;
    localparam logic [ADDR_W-1:0] TMR_IDX_MASK = 9'h00C;

    // ----------------------------------------------------------------
    // field layouts
    // ----------------------------------------------------------------
    localparam int MODE_W = 3;
    localparam int EDGE_W = 2;
    localparam int SEL_W = 3;
    localparam int SRC_W = 2;
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_TSEL_BIT = 3;
    localparam int CTL_EDGE_LSB = 4;
    localparam int EDGE_RISE_BIT = 0;
    localparam int EDGE_FALL_BIT = 1;
    localparam int TC_SEL_LSB = 0;
    localparam int TC_SRC_LSB = 3;
    localparam int TC_RUN_BIT = 5;

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_OFF = 3'h0;
    localparam logic [MODE_W-1:0] MODE_CAPTURE = 3'h1;
    localparam logic [MODE_W-1:0] MODE_CMP0 = 3'h2;
    localparam logic [MODE_W-1:0] MODE_CMP1 = 3'h3;
    localparam logic [MODE_W-1:0] MODE_CMP2 = 3'h4;
    localparam logic [MODE_W-1:0] MODE_CMP3 = 3'h5;
    localparam logic [MODE_W-1:0] MODE_DOUBLE = 3'h6;
    localparam logic [SRC_W-1:0] SRC_PRESCALE = 2'h0;
    localparam logic [SRC_W-1:0] SRC_GP_OVF = 2'h1;
    localparam logic [SRC_W-1:0] SRC_EXT = 2'h2;

endpackage

// >>> dcca_properties.sv
`timescale 1ns/1ps
module dcca_properties
    import dcca_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // pins and requests
    input wire logic [31:0] cc_pin_out,
    input wire logic [31:0] cc_pin_oe,
    input wire logic [31:0] chan_irq,
    input wire logic [3:0] timer_irq
);
    // ------------------------------------------------------------
    // steps
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd(logic [8:0] a);
        wb_ack_o && !wb_we_i && wb_adr_i[8:2] == a[8:2];
    endsequence
    // flags may only drop on a write-one-clear access
    wire wr_cf = wb_ack_o && wb_we_i && wb_adr_i[8:2] == ADDR_CH_FLAG[8:2];
    wire wr_tf = wb_ack_o && wb_we_i && wb_adr_i[8:2] == ADDR_TMR_FLAG[8:2];
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_ack_next; s_req |=> wb_ack_o; endproperty
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    property p_oe_in_only; cc_pin_oe[27:24] == 4'h0; endproperty
    property p_oe_by_wr; $changed(cc_pin_oe) |-> $past(wb_ack_o && wb_we_i); endproperty
    property p_ch_sticky; |($past(chan_irq) & ~chan_irq) |-> $past(wr_cf); endproperty
    property p_tm_sticky; |($past(timer_irq) & ~timer_irq) |-> $past(wr_tf); endproperty
    property p_pin_rd; s_rd(ADDR_PIN_LVL) |-> wb_dat_o == $past(cc_pin_out); endproperty
    property p_cf_rd; s_rd(ADDR_CH_FLAG) |-> wb_dat_o == $past(chan_irq); endproperty
    property p_tf_rd; s_rd(ADDR_TMR_FLAG) |-> wb_dat_o[3:0] == $past(timer_irq); endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    a_ack_once: assert property (p_ack_once) else $error("ack longer than a cycle");
    a_oe_in_only: assert property (p_oe_in_only)
        else $error("input only pin driven");
    a_oe_by_wr: assert property (p_oe_by_wr)
        else $error("pin enable changed without write");
    a_ch_sticky: assert property (p_ch_sticky)
        else $error("channel request dropped by itself");
    a_tm_sticky: assert property (p_tm_sticky)
        else $error("timer request dropped by itself");
    a_pin_rd: assert property (p_pin_rd)
        else $error("pin level read differs");
    a_cf_rd: assert property (p_cf_rd)
        else $error("channel flag read differs");
    a_tf_rd: assert property (p_tf_rd)
        else $error("timer flag read differs");
endmodule

// >>> dcca_pin_model.sv
`timescale 1ns/1ps
module dcca_pin_model (
    // device drive
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    // levels seen by the device
    output logic [31:0] pin_lvl
);
    logic [31:0] ext_q = 32'h0;
    // a driven pin shows the device level, the outside loses
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_q);
    task automatic set_pin(input int i, input logic v);
        ext_q[i] <= v;
    endtask
endmodule

// >>> tb_dual_capture_compare_array.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_dual_capture_compare_array import dcca_pkg::*;;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [ADDR_W-1:0] wb_adr_i = 9'h000;
    logic [3:0] wb_sel_i = 4'h0, timer_irq;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, cc_pin_in, cc_pin_out, cc_pin_oe, chan_irq;
    logic [1:0] ext_count_in = 2'h0;
    logic gp_timer_ovf = 1'b0;
    int n_fail = 0, checks_done = 0, cyc_n = 0, seed = 89;
    logic [31:0] exp_q[$];
    logic [31:0] rd, ex, v, k1, k2;
    logic [2:0] md[4] = '{MODE_CMP1, MODE_CMP0, MODE_CMP2, MODE_CMP3};
    // ------------------------------------------------------------
    // clock, parts
    // ------------------------------------------------------------
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) cyc_n <= cyc_n + 1;
    dcca_core dcca_core_i (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .cc_pin_in(cc_pin_in), .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe),
        .ext_count_in(ext_count_in), .gp_timer_ovf(gp_timer_ovf), .chan_irq(chan_irq),
        .timer_irq(timer_irq));
    dcca_pin_model dcca_pin_model_i (.pin_out(cc_pin_out), .pin_oe(cc_pin_oe),
        .pin_lvl(cc_pin_in));
    // ------------------------------------------------------------
    // bus and checking
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int t;
        t = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 100);
        if (t >= 100) n_fail++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask
    task automatic rc(input logic [8:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0, rd);
    endtask
    // one-cycle overflow pulses with gaps, then settle
    task automatic gp(input int n);
        repeat (n) begin
            gp_timer_ovf <= 1'b1;
            @(posedge clk);
            gp_timer_ovf <= 1'b0;
            repeat (2) @(posedge clk);
        end
        repeat (3) @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i && exp_q.size() > 0) begin
            ex = exp_q.pop_front();
            `CHK(wb_dat_o, ex)
        end
    end
    task automatic end_sim();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #(50 * 40000);
        n_fail++;
        end_sim();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rc(ADDR_TMR_CNT, 32'h0);
        rc(9'h1FC, 32'h0);
        rc(ADDR_CH_FLAG, 32'h0);
        // whole prescale periods, so the free-running phase drops out
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_TMR_CTL, 32'h20 | c);
            k1 = cyc_n;
            bus(1'b0, ADDR_TMR_CNT, 32'h0, v);
            while (cyc_n < k1 + 3 * (8 << c)) @(posedge clk);
            rc(ADDR_TMR_CNT, v + 32'h3);
        end
        for (int u = 0; u < 2; u++) begin
            k2 = 32'h1 + ($random(seed) & 32'h7);
            wr(ADDR_TMR_CTL + 9'(8 * u), 32'h30);
            wr(ADDR_TMR_CNT + 9'(8 * u), 32'h0);
            repeat (k2) begin
                ext_count_in[u] <= 1'b1;
                repeat (3) @(posedge clk);
                ext_count_in[u] <= 1'b0;
                repeat (3) @(posedge clk);
            end
            rc(ADDR_TMR_CNT + 9'(8 * u), k2);
            wr(ADDR_TMR_CTL + 9'(8 * u), 32'h18);
        end
        // capture on channel 16 from unit two timer b, held still
        wr(ADDR_TMR_CTL + 9'hC, 32'h18);
        for (int g = 1; g < 4; g++) begin
            k1 = $random(seed) & 32'hFFFF;
            k2 = $random(seed) & 32'hFFFF;
            wr(ADDR_CH_CTL + 9'h40, 32'h9 | (g << 4));
            wr(ADDR_TMR_CNT + 9'hC, k1);
            dcca_pin_model_i.set_pin(16, 1'b1);
            repeat (6) @(posedge clk);
            wr(ADDR_TMR_CNT + 9'hC, k2);
            dcca_pin_model_i.set_pin(16, 1'b0);
            repeat (6) @(posedge clk);
            rc(ADDR_CH_VAL + 9'h40, (g == 1) ? k1 : k2);
            rc(ADDR_CH_FLAG, 32'h10000);
            wr(ADDR_CH_FLAG, 32'h10000);
        end
        // compare modes on channels 0..3, timer 0 fed by gp overflow
        v = 32'h100 + ($random(seed) & 32'hFF);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CH_VAL + 9'(4 * i), v);
            wr(ADDR_CH_CTL + 9'(4 * i), 32'(md[i]));
        end
        wr(ADDR_CH_CTL + 9'h60, 32'(MODE_CMP1));
        wr(ADDR_TMR_CNT, v - 32'h1);
        wr(ADDR_TMR_CTL, 32'h28);
        gp(1);
        rc(ADDR_PIN_LVL, 32'h9);
        rc(ADDR_CH_FLAG, 32'hF);
        `CHK(cc_pin_oe, 32'h9)
        wr(ADDR_CH_FLAG, 32'hF);
        repeat (8) @(posedge clk);
        rc(ADDR_CH_FLAG, 32'h0);
        wr(ADDR_TMR_CNT, v - 32'h1);
        gp(1);
        rc(ADDR_PIN_LVL, 32'h8);
        rc(ADDR_CH_FLAG, 32'h3);
        wr(ADDR_CH_FLAG, 32'h3);
        wr(ADDR_TMR_CNT, 32'hFFFF);
        gp(1);
        rc(ADDR_PIN_LVL, 32'h0);
        rc(ADDR_TMR_FLAG, 32'h1);
        `CHK(timer_irq, 4'h1)
        wr(ADDR_TMR_CNT, v - 32'h1);
        gp(1);
        rc(ADDR_CH_FLAG, 32'hF);
        `CHK(chan_irq, 32'hF)
        `CHK(cc_pin_out, 32'h9)
        // double mode: channels 4 and 12 share pin 4
        wr(ADDR_CH_VAL + 9'h10, v + 32'h1);
        wr(ADDR_CH_CTL + 9'h10, 32'(MODE_DOUBLE));
        wr(ADDR_CH_VAL + 9'h30, v + 32'h2);
        wr(ADDR_CH_CTL + 9'h30, 32'(MODE_DOUBLE));
        `CHK(cc_pin_oe, 32'h19)
        gp(1);
        rc(ADDR_PIN_LVL, 32'h19);
        gp(1);
        rc(ADDR_PIN_LVL, 32'h9);
        rc(ADDR_CH_FLAG, 32'h101F);
        wr(ADDR_TMR_CTL, 32'h18);
        // reload after overflow on unit two timer b
        k1 = $random(seed) & 32'hFFFF;
        wr(ADDR_TMR_RLD + 9'hC, k1);
        wr(ADDR_TMR_CNT + 9'hC, 32'hFFFE);
        wr(ADDR_TMR_CTL + 9'hC, 32'h28);
        gp(2);
        rc(ADDR_TMR_CNT + 9'hC, k1);
        wr(ADDR_TMR_FLAG, 32'h1);
        rc(ADDR_TMR_FLAG, 32'h8);
        wr(ADDR_TMR_FLAG, 32'h8);
        rc(ADDR_TMR_FLAG, 32'h0);
        // second reset in mid-run
        reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rc(ADDR_TMR_RLD + 9'hC, 32'h0);
        end_sim();
    end
endmodule
bind dcca_core dcca_properties dcca_properties_i (.clk(clk), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cc_pin_out(cc_pin_out),
    .cc_pin_oe(cc_pin_oe), .chan_irq(chan_irq), .timer_irq(timer_irq));
